//--- vac_regs.svh
`ifndef VAC_REGS_SVH
`define VAC_REGS_SVH

// i/o port addresses (10-bit decode)
`define VAC_IO_MODE_ADDR      10'h3d8
`define VAC_IO_PALETTE_ADDR   10'h3d9
`define VAC_IO_STATUS_ADDR    10'h3da
`define VAC_IO_PEN_CLR_ADDR   10'h3db
`define VAC_IO_PEN_SET_ADDR   10'h3dc

// display buffer window: 16k bytes at b8000
`define VAC_MEM_BASE          20'hb8000
`define VAC_MEM_WIN_BITS      6
`define VAC_MEM_WIN_TAG       6'h2e
`define VAC_MEM_AW            14
`define VAC_MEM_BYTES         16384

// mode-select fields
`define VAC_MODE_W            6
`define VAC_MODE_RESET        6'h00
`define VAC_MODE_COL80        0
`define VAC_MODE_GFX          1
`define VAC_MODE_BW           2
`define VAC_MODE_VID_EN       3
`define VAC_MODE_HIRES        4
`define VAC_MODE_BLINK        5

// colour-select fields
`define VAC_PAL_W             6
`define VAC_PAL_RESET         6'h00
`define VAC_PAL_IRGB_LSB      0
`define VAC_PAL_INTENS        4
`define VAC_PAL_SET           5

// status fields
`define VAC_ST_ACCESS_OK      0
`define VAC_ST_PEN_TRIG       1
`define VAC_ST_PEN_SW         2
`define VAC_ST_VRETRACE       3

// read value of a write-only port (no stored state is returned)
`define VAC_WO_READ_VALUE     8'hff

// fixed irgb colour codes
`define VAC_IRGB_BLACK        4'h0
`define VAC_IRGB_GREEN        3'h2
`define VAC_IRGB_CYAN         3'h3
`define VAC_IRGB_RED          3'h4
`define VAC_IRGB_MAGENTA      3'h5
`define VAC_IRGB_BROWN        3'h6
`define VAC_IRGB_WHITE        3'h7

`endif

//--- vac_pkg.sv
package vac_pkg;

    // display mode decoded from the mode-select register
    typedef enum logic [1:0] {
        VAC_TEXT40  = 2'b00,
        VAC_TEXT80  = 2'b01,
        VAC_GFX_MED = 2'b10,
        VAC_GFX_HI  = 2'b11
    } vac_mode_e;

    typedef logic [3:0] vac_irgb_t;
    typedef logic [7:0] vac_byte_t;

endpackage

//--- vac_video_adapter_control_regs.sv
`timescale 1ns/1ns
`include "vac_regs.svh"
module vac_video_adapter_control_regs (
    input  wire logic              core_clk,
    input  wire logic              rst,
    // processor i/o port cycles
    input  wire logic [9:0]        io_addr,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    input  wire vac_pkg::vac_byte_t io_wdata,
    output logic      [7:0]        io_rdata,
    output logic                   io_rd_ack,
    // processor memory cycles
    input  wire logic [19:0]       mem_addr,
    input  wire logic              mem_wr,
    input  wire logic              mem_rd,
    input  wire vac_pkg::vac_byte_t mem_wdata,
    output logic      [7:0]        mem_rdata,
    output logic                   mem_ack,
    // refresh side from the timing controller (same clock)
    input  wire logic [13:0]       vid_addr,
    output logic      [7:0]        vid_data,
    input  wire logic              crt_disp_en,
    input  wire logic              crt_vsync,
    input  wire logic              text_pixel_on,
    input  wire logic [3:0]        text_fg_irgb,
    input  wire logic [3:0]        text_bg_attr,
    input  wire logic              blink_phase,
    input  wire logic              pixel_code_low,
    input  wire logic              pixel_code_high,
    // light pen pins
    input  wire logic              pen_trigger_in,
    input  wire logic              pen_switch_n_in,
    // mode levels to the timing logic and video out
    output vac_pkg::vac_mode_e     disp_mode,
    output logic                   mono_out,
    output logic                   video_on,
    output vac_pkg::vac_irgb_t     video_irgb
);
    import vac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic io_hit(input logic [9:0] a, input logic [9:0] port);
        io_hit = (a == port);
    endfunction

    function automatic logic mem_hit(input logic [19:0] a);
        mem_hit = (a[19:`VAC_MEM_AW] == `VAC_MEM_WIN_TAG);
    endfunction

    // glyph bit over the background, blanked in the hidden blink phase
    function automatic vac_irgb_t text_colour(input logic on, input logic hide,
                                              input vac_irgb_t fg, input vac_irgb_t bg);
        if (on && !hide) begin
            text_colour = fg;
        end else begin
            text_colour = bg;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register writes

    logic [`VAC_MODE_W-1:0] mode_q;
    logic [`VAC_PAL_W-1:0]  pal_q;

    // reset leaves video gated off until software enables it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= `VAC_MODE_RESET;
        end else if (io_wr && io_hit(io_addr, `VAC_IO_MODE_ADDR)) begin
            mode_q <= io_wdata[`VAC_MODE_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pal_q <= `VAC_PAL_RESET;
        end else if (io_wr && io_hit(io_addr, `VAC_IO_PALETTE_ADDR)) begin
            pal_q <= io_wdata[`VAC_PAL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // light pen inputs: two-stage synchronisers, then edge detect

    logic pen_trig_s1_q;
    logic pen_trig_s2_q;
    logic pen_trig_s3_q;
    logic pen_sw_s1_q;
    logic pen_sw_s2_q;
    logic pen_latch_q;
    logic pen_rise;
    logic pen_clr;
    logic pen_set;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pen_trig_s1_q <= 1'b0;
            pen_trig_s2_q <= 1'b0;
            pen_trig_s3_q <= 1'b0;
        end else begin
            pen_trig_s1_q <= pen_trigger_in;
            pen_trig_s2_q <= pen_trig_s1_q;
            pen_trig_s3_q <= pen_trig_s2_q;
        end
    end

    // switch reset to 1 (open) so status never shows a false press
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pen_sw_s1_q <= 1'b1;
            pen_sw_s2_q <= 1'b1;
        end else begin
            pen_sw_s1_q <= pen_switch_n_in;
            pen_sw_s2_q <= pen_sw_s1_q;
        end
    end

    assign pen_rise = pen_trig_s2_q && !pen_trig_s3_q;
    assign pen_clr  = io_wr && io_hit(io_addr, `VAC_IO_PEN_CLR_ADDR);
    assign pen_set  = io_wr && io_hit(io_addr, `VAC_IO_PEN_SET_ADDR);

    // an edge in the clearing cycle is kept: set beats clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pen_latch_q <= 1'b0;
        end else if (pen_rise || pen_set) begin
            pen_latch_q <= 1'b1;
        end else if (pen_clr) begin
            pen_latch_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status read, one cycle after the in strobe

    logic [3:0] status;
    logic       rd_status;
    logic       rd_wo_port;

    assign rd_status  = io_rd && io_hit(io_addr, `VAC_IO_STATUS_ADDR);
    assign rd_wo_port = io_rd && (io_hit(io_addr, `VAC_IO_MODE_ADDR) ||
                                  io_hit(io_addr, `VAC_IO_PALETTE_ADDR));

    always_comb begin
        status = 4'h0;
        status[`VAC_ST_ACCESS_OK] = !crt_disp_en;
        status[`VAC_ST_PEN_TRIG]  = pen_latch_q;
        status[`VAC_ST_PEN_SW]    = pen_sw_s2_q;
        status[`VAC_ST_VRETRACE]  = crt_vsync;
    end

    // mode and colour-select ports answer with all ones, not their contents; pen clear/set reads get no answer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            io_rdata  <= 8'h00;
            io_rd_ack <= 1'b0;
        end else begin
            io_rd_ack <= 1'b0;
            if (rd_status) begin
                io_rdata  <= {4'h0, status};
                io_rd_ack <= 1'b1;
            end else if (rd_wo_port) begin
                io_rdata  <= `VAC_WO_READ_VALUE;
                io_rd_ack <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // display buffer: no parity bits are kept

    logic [7:0] vbuf [0:`VAC_MEM_BYTES-1];

    always_ff @(posedge core_clk) begin
        if (mem_wr && mem_hit(mem_addr)) begin
            vbuf[mem_addr[`VAC_MEM_AW-1:0]] <= mem_wdata;
        end
    end

    // ram contents are not reset; only the handshake, read data and vid_data are
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 8'h00;
        end else begin
            mem_ack <= (mem_wr || mem_rd) && mem_hit(mem_addr);
            if (mem_rd && mem_hit(mem_addr)) begin
                mem_rdata <= vbuf[mem_addr[`VAC_MEM_AW-1:0]];
            end
        end
    end

    // refresh port never stalls the processor; tearing is avoided only
    // if software waits for status bit 0 or 3
    always_ff @(posedge core_clk) begin
        if (rst) begin
            vid_data <= 8'h00;
        end else begin
            vid_data <= vbuf[vid_addr];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode decode

    vac_mode_e mode_sel;

    // hi-res bit wins over the graphics and width bits
    always_comb begin
        if (mode_q[`VAC_MODE_HIRES]) begin
            mode_sel = VAC_GFX_HI;
        end else if (mode_q[`VAC_MODE_GFX]) begin
            mode_sel = VAC_GFX_MED;
        end else if (mode_q[`VAC_MODE_COL80]) begin
            mode_sel = VAC_TEXT80;
        end else begin
            mode_sel = VAC_TEXT40;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // colour generation

    logic [3:0] pal_irgb;
    logic [3:0] text_bg;
    logic       blink_hide;
    logic [2:0] med_rgb;
    logic [3:0] pix_d;

    assign pal_irgb = pal_q[`VAC_PAL_IRGB_LSB +: 4];

    // blink mode gives up the background intensity bit
    always_comb begin
        if (mode_q[`VAC_MODE_BLINK]) begin
            text_bg    = {pal_q[`VAC_PAL_INTENS], text_bg_attr[2:0]};
            blink_hide = text_bg_attr[3] && blink_phase;
        end else begin
            text_bg    = text_bg_attr | {pal_q[`VAC_PAL_INTENS], 3'b000};
            blink_hide = 1'b0;
        end
    end

    // code 00 is the background, picked below
    always_comb begin
        case ({pal_q[`VAC_PAL_SET], pixel_code_high, pixel_code_low})
            3'b101:  med_rgb = `VAC_IRGB_CYAN;
            3'b110:  med_rgb = `VAC_IRGB_MAGENTA;
            3'b111:  med_rgb = `VAC_IRGB_WHITE;
            3'b001:  med_rgb = `VAC_IRGB_GREEN;
            3'b010:  med_rgb = `VAC_IRGB_RED;
            3'b011:  med_rgb = `VAC_IRGB_BROWN;
            default: med_rgb = 3'b000;
        endcase
    end

    always_comb begin
        pix_d = `VAC_IRGB_BLACK;
        case (mode_sel)
            VAC_TEXT40: begin
                if (!crt_disp_en) begin
                    pix_d = pal_irgb;
                end else begin
                    pix_d = text_colour(text_pixel_on, blink_hide, text_fg_irgb, text_bg);
                end
            end
            VAC_TEXT80: begin
                if (!crt_disp_en) begin
                    pix_d = `VAC_IRGB_BLACK;
                end else begin
                    pix_d = text_colour(text_pixel_on, blink_hide, text_fg_irgb, text_bg);
                end
            end
            VAC_GFX_MED: begin
                if (!crt_disp_en || {pixel_code_high, pixel_code_low} == 2'b00) begin
                    pix_d = pal_irgb;
                end else begin
                    pix_d = {pal_q[`VAC_PAL_INTENS], med_rgb};
                end
            end
            VAC_GFX_HI: begin
                if (crt_disp_en && pixel_code_low) begin
                    pix_d = pal_irgb;
                end else begin
                    pix_d = `VAC_IRGB_BLACK;
                end
            end
            default: pix_d = `VAC_IRGB_BLACK;
        endcase
    end

    // video gate: software drops it across a mode change
    always_ff @(posedge core_clk) begin
        if (rst) begin
            video_irgb <= `VAC_IRGB_BLACK;
        end else if (mode_q[`VAC_MODE_VID_EN]) begin
            video_irgb <= pix_d;
        end else begin
            video_irgb <= `VAC_IRGB_BLACK;
        end
    end

    // levels lag the register by one cycle, like video_irgb
    always_ff @(posedge core_clk) begin
        if (rst) begin
            disp_mode <= VAC_TEXT40;
            mono_out  <= 1'b0;
            video_on  <= 1'b0;
        end else begin
            disp_mode <= mode_sel;
            mono_out  <= mode_q[`VAC_MODE_BW];
            video_on  <= mode_q[`VAC_MODE_VID_EN];
        end
    end

endmodule // vac_video_adapter_control_regs

//--- vac_chk.sv
`timescale 1ns/1ns
module vac_chk (
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic [9:0]         io_addr,
    input wire logic               io_wr,
    input wire logic               io_rd,
    input wire vac_pkg::vac_byte_t io_wdata,
    input wire logic [7:0]         io_rdata,
    input wire logic               io_rd_ack,
    input wire logic [19:0]        mem_addr,
    input wire logic               mem_wr,
    input wire logic               mem_rd,
    input wire logic               mem_ack,
    input wire logic               crt_disp_en,
    input wire logic               crt_vsync,
    input wire logic               mono_out,
    input wire logic               video_on
);
    import vac_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    read_ack_a: assert property (io_rd && io_addr inside {[10'h3d8:10'h3da]} |=> io_rd_ack)
        else $error("read of a mapped port not answered");
    no_ack_a: assert property (io_rd && io_addr == 10'h3db |=> !io_rd_ack)
        else $error("read of an unmapped port answered");
    status_val_a: assert property (io_rd && io_addr == 10'h3da |=> io_rdata[7:4] == 4'h0
        && io_rdata[3] == $past(crt_vsync) && io_rdata[0] == !$past(crt_disp_en))
        else $error("status read value wrong");
    wo_hidden_a: assert property (io_rd && io_addr inside {10'h3d8, 10'h3d9} |=> io_rdata == 8'hff)
        else $error("write-only port showed contents");
    video_gate_a: assert property (io_wr && io_addr == 10'h3d8 |=> ##1 video_on == $past(io_wdata[3], 2))
        else $error("video enable not taken from mode bit 3");
    mono_sel_a: assert property (io_wr && io_addr == 10'h3d8 |=> ##1 mono_out == $past(io_wdata[2], 2))
        else $error("mono select not taken from mode bit 2");
    mem_ack_a: assert property ((mem_rd || mem_wr) && mem_addr[19:14] == 6'h2e |=> mem_ack)
        else $error("buffer access not answered");
    mem_out_a: assert property (!(mem_rd || mem_wr) || mem_addr[19:14] != 6'h2e |=> !mem_ack)
        else $error("access outside the buffer answered");
endmodule // vac_chk

bind vac_video_adapter_control_regs vac_chk u_chk (
    .core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_ack(mem_ack), .crt_disp_en(crt_disp_en),
    .crt_vsync(crt_vsync), .mono_out(mono_out), .video_on(video_on)
);

//--- vac_pen_model.sv
`timescale 1ns/1ns
module vac_pen_model (
    input  wire logic core_clk,
    input  wire logic flash,
    input  wire logic press,
    output logic      pen_trigger_in,
    output logic      pen_switch_n_in
);
    // two-cycle pulse so the pin synchroniser cannot miss it
    logic [1:0] cnt_q = 2'h0;
    always_ff @(posedge core_clk) begin
        cnt_q <= flash ? 2'h2 : (cnt_q != 2'h0 ? cnt_q - 2'h1 : 2'h0);
    end
    assign pen_trigger_in  = (cnt_q != 2'h0);
    assign pen_switch_n_in = !press;
endmodule // vac_pen_model

//--- vac_video_adapter_control_regs_tb_top.sv
`timescale 1ns/1ns
`include "vac_regs.svh"
module vac_video_adapter_control_regs_tb_top;
    import vac_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
    logic [9:0] io_addr = 10'h0;
    logic [19:0] mem_addr = 20'h0;
    logic [13:0] vid_addr = 14'h0;
    vac_byte_t io_wdata = 8'h0, mem_wdata = 8'h0;
    logic crt_disp_en = 1'b1, crt_vsync = 1'b0, pcl = 1'b0, pch = 1'b0, flash = 1'b0, press = 1'b0;
    logic pen_trig, pen_sw_n, io_rd_ack, mem_ack, mono_out, video_on;
    logic tpo = 1'b0, bph = 1'b0;
    logic [3:0] tfg = 4'h0, tbg = 4'h0;
    logic [7:0] io_rdata, mem_rdata, vid_data;
    vac_mode_e disp_mode;
    vac_irgb_t video_irgb;
    int fail_count = 0, checked = 0;
    always #10 core_clk = ~core_clk;
    vac_pen_model u_pen (.core_clk(core_clk), .flash(flash), .press(press),
        .pen_trigger_in(pen_trig), .pen_switch_n_in(pen_sw_n));
    vac_video_adapter_control_regs DUT (.core_clk(core_clk), .rst(rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rd_ack(io_rd_ack), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .vid_addr(vid_addr),
        .vid_data(vid_data), .crt_disp_en(crt_disp_en), .crt_vsync(crt_vsync),
        .text_pixel_on(tpo), .text_fg_irgb(tfg), .text_bg_attr(tbg), .blink_phase(bph),
        .pixel_code_low(pcl), .pixel_code_high(pch), .pen_trigger_in(pen_trig),
        .pen_switch_n_in(pen_sw_n), .disp_mode(disp_mode), .mono_out(mono_out),
        .video_on(video_on), .video_irgb(video_irgb));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic io_w(input logic [9:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge core_clk);
        io_wr = 1'b0;
    endtask
    // answer latency is exactly one cycle, so no polling
    task automatic io_r(input logic [9:0] a, input logic want, input logic [7:0] exp);
        @(negedge core_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge core_clk);
        io_rd = 1'b0;
        chk({7'h0, io_rd_ack}, {7'h0, want});
        if (want) chk(io_rdata, exp);
    endtask
    task automatic mem_x(input logic [19:0] a, input logic w, input logic [7:0] d, input logic want);
        @(negedge core_clk);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = w;
        mem_rd = !w;
        @(negedge core_clk);
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        chk({7'h0, mem_ack}, {7'h0, want});
        if (!w && want) chk(mem_rdata, d);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_modes();
        logic [7:0] mv [6] = '{8'h09, 8'h08, 8'h0a, 8'h1e, 8'hc4, 8'h2d};
        vac_mode_e em;
        foreach (mv[i]) begin
            io_w(`VAC_IO_MODE_ADDR, 8'h00);
            io_w(`VAC_IO_MODE_ADDR, mv[i]);
            @(negedge core_clk);
            em = mv[i][4] ? VAC_GFX_HI : mv[i][1] ? VAC_GFX_MED : mv[i][0] ? VAC_TEXT80 : VAC_TEXT40;
            chk({4'h0, disp_mode, mono_out, video_on}, {4'h0, em, mv[i][2], mv[i][3]});
        end
        $display("modes done");
    endtask
    task automatic t_palette();
        logic [7:0] pv [4] = '{8'h21, 8'h01, 8'h13, 8'hc1};
        logic [1:0] c;
        io_w(`VAC_IO_MODE_ADDR, 8'h00);
        io_w(`VAC_IO_MODE_ADDR, 8'h0a);
        foreach (pv[i]) begin
            io_w(`VAC_IO_PALETTE_ADDR, pv[i]);
            for (int k = 0; k < 4; k++) begin
                c = k[1:0];
                @(negedge core_clk);
                {pch, pcl} = c;
                @(negedge core_clk);
                chk({4'h0, video_irgb}, {4'h0, c == 2'h0 ? pv[i][3:0] : {pv[i][4], c, pv[i][5]}});
            end
        end
        io_w(`VAC_IO_MODE_ADDR, 8'h02);
        @(negedge core_clk);
        chk({4'h0, video_irgb}, 8'h00);
        io_w(`VAC_IO_MODE_ADDR, 8'h08);
        io_w(`VAC_IO_PALETTE_ADDR, 8'h2c);
        crt_disp_en = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({4'h0, video_irgb}, 8'h0c);
        crt_disp_en = 1'b1;
        $display("palette done");
    endtask
    task automatic px(input logic on, input logic [3:0] fg, input logic [3:0] at,
                      input logic ph, input logic [7:0] exp);
        @(negedge core_clk);
        tpo = on;
        tfg = fg;
        tbg = at;
        bph = ph;
        @(negedge core_clk);
        chk({4'h0, video_irgb}, exp);
    endtask
    task automatic t_text();
        io_w(`VAC_IO_MODE_ADDR, 8'h00);
        io_w(`VAC_IO_PALETTE_ADDR, 8'h1c);
        io_w(`VAC_IO_MODE_ADDR, 8'h09);
        crt_disp_en = 1'b0;
        px(1'b1, 4'h9, 4'ha, 1'b1, 8'h00);
        crt_disp_en = 1'b1;
        px(1'b1, 4'h9, 4'ha, 1'b1, 8'h09);
        px(1'b0, 4'h9, 4'h2, 1'b1, 8'h0a);
        io_w(`VAC_IO_MODE_ADDR, 8'h00);
        io_w(`VAC_IO_PALETTE_ADDR, 8'h0c);
        io_w(`VAC_IO_MODE_ADDR, 8'h29);
        px(1'b1, 4'h9, 4'ha, 1'b1, 8'h02);
        px(1'b1, 4'h9, 4'ha, 1'b0, 8'h09);
        px(1'b0, 4'h9, 4'ha, 1'b0, 8'h02);
        io_w(`VAC_IO_MODE_ADDR, 8'h00);
        io_w(`VAC_IO_PALETTE_ADDR, 8'h05);
        io_w(`VAC_IO_MODE_ADDR, 8'h18);
        pcl = 1'b1;
        px(1'b0, 4'h0, 4'h0, 1'b0, 8'h05);
        pcl = 1'b0;
        px(1'b0, 4'h0, 4'h0, 1'b0, 8'h00);
        $display("text done");
    endtask
    task automatic t_status();
        @(negedge core_clk);
        crt_disp_en = 1'b0;
        crt_vsync = 1'b1;
        press = 1'b1;
        repeat (4) @(negedge core_clk);
        io_r(`VAC_IO_STATUS_ADDR, 1'b1, 8'h09);
        crt_disp_en = 1'b1;
        crt_vsync = 1'b0;
        press = 1'b0;
        repeat (4) @(negedge core_clk);
        io_r(`VAC_IO_STATUS_ADDR, 1'b1, 8'h04);
        io_r(`VAC_IO_MODE_ADDR, 1'b1, 8'hff);
        io_r(`VAC_IO_PALETTE_ADDR, 1'b1, 8'hff);
        io_r(`VAC_IO_PEN_CLR_ADDR, 1'b0, 8'h00);
        $display("status done");
    endtask
    task automatic t_pen();
        @(negedge core_clk);
        flash = 1'b1;
        @(negedge core_clk);
        flash = 1'b0;
        repeat (6) @(negedge core_clk);
        io_r(`VAC_IO_STATUS_ADDR, 1'b1, 8'h06);
        io_w(`VAC_IO_PEN_CLR_ADDR, 8'h5a);
        io_r(`VAC_IO_STATUS_ADDR, 1'b1, 8'h04);
        io_w(`VAC_IO_PEN_SET_ADDR, 8'h00);
        io_r(`VAC_IO_STATUS_ADDR, 1'b1, 8'h06);
        io_w(`VAC_IO_PEN_CLR_ADDR, 8'h00);
        io_r(`VAC_IO_STATUS_ADDR, 1'b1, 8'h04);
        $display("pen done");
    endtask
    task automatic t_mem();
        mem_x(20'hb8005, 1'b1, 8'h41, 1'b1);
        mem_x(20'hb8005, 1'b0, 8'h41, 1'b1);
        vid_addr = 14'h0005;
        @(negedge core_clk);
        chk(vid_data, 8'h41);
        mem_x(20'hbbfff, 1'b1, 8'h7e, 1'b1);
        mem_x(20'hbc000, 1'b1, 8'h11, 1'b0);
        mem_x(20'hb7fff, 1'b0, 8'h00, 1'b0);
        mem_x(20'hbbfff, 1'b0, 8'h7e, 1'b1);
        $display("memory done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        chk({2'h0, disp_mode, video_on, mono_out, io_rd_ack, mem_ack}, 8'h00);
        io_r(`VAC_IO_STATUS_ADDR, 1'b1, 8'h04);
        $display("reset done");
        t_modes();
        t_palette();
        t_text();
        t_status();
        t_pen();
        t_mem();
        complete_run();
    end
endmodule // vac_video_adapter_control_regs_tb_top
